// ---- core/array_switch_ctl.sv ----
// Purpose: Switch drive for one capacitive array
// Assumes: Trial mask registered by the sequencer
// Notes: Instanced once per comparator input
`timescale 1ns/10ps
module array_switch_ctl
    import sar_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic acquire_in,
    input wire logic sample_open_in,
    input wire logic [CODE_W-1:0] ref_mask_in,
    output array_drive_t drive_out
);
    array_drive_t drive_d;
    array_drive_t drive_q;

    always_comb begin
        drive_d.sample_closed = acquire_in && !sample_open_in;
        drive_d.to_input = acquire_in;
        drive_d.to_ref = acquire_in ? CODE_ZERO : ref_mask_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            drive_q <= '{sample_closed: 1'b1, to_input: 1'b1,
                         to_ref: CODE_ZERO};
        end else begin
            drive_q <= drive_d;
        end
    end

    assign drive_out = drive_q;
endmodule

// ---- core/conv_clock_div.sv ----
// Purpose: Internal conversion clock as a one-cycle enable
// Assumes: Single system clock
// Notes: Free running, independent of any serial clock
`timescale 1ns/10ps
module conv_clock_div
    import sar_seq_pkg::*;
#(
    parameter int unsigned DIV = 2
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    output logic tick_out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb begin
        if (cnt_q == 8'(DIV - 1)) begin
            cnt_d = 8'h00;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick_out = (cnt_q == 8'(DIV - 1));
endmodule

// ---- core/sar_conversion_sequencer.sv ----
// Purpose: Successive-approximation sequencer for a 16-bit converter
// Assumes: Comparator decision synchronous to clk_in, settled per tick
// Notes: Over/under-range clamp falls out of the binary search
// Contract
// - In acquisition both sampling switches ground the plates, elements to inputs.
// - A conversion starts only on a rising convert strobe after acquisition.
// - Sampling switches open first, then arrays move from inputs to ground.
// - Two identical arrays of 16 binary-weighted elements are steered.
// - Elements trial one at a time from the MSB, steps halving to 1/65536.
// - After the trials the core powers down, re-acquires, gives code and busy.
// - Steps are timed by the internal conversion clock, not the serial clock.
// - The code is straight binary of input over reference.
// - Over-range input yields FFFF.
// - Under-range input yields 0000.
// - Each result belongs to its own conversion, no latency.
// - The cycle sustains 250 kSPS and powers down between conversions.
`timescale 1ns/10ps
module sar_conversion_sequencer
    import sar_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic convert_strobe_in,
    input wire logic comp_above_in,
    output array_drive_t pos_array_out,
    output array_drive_t neg_array_out,
    output logic positive_sample_switch_out,
    output logic negative_sample_switch_out,
    output logic powered_out,
    output logic busy_out,
    output result_t result_out
);
    // ****************************************
    // Conversion clock
    // ****************************************
    logic tick;

    conv_clock_div #(.DIV(CONV_DIV)) u_div (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_out(tick)
    );

    // ****************************************
    // Sequencer state
    // ****************************************
    seq_state_t state_q;
    seq_state_t state_d;
    logic strobe_q;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [CODE_W-1:0] sar_q;
    logic [CODE_W-1:0] sar_d;
    result_t result_q;
    result_t result_d;
    logic busy_q;
    logic busy_d;
    logic strobe_rise;

    assign strobe_rise = convert_strobe_in && !strobe_q;

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        sar_d = sar_q;
        result_d = result_q;
        result_d.valid = 1'b0;
        busy_d = busy_q;
        case (state_q)
            ST_ACQ: begin
                if (strobe_rise) begin
                    state_d = ST_OPEN;
                    busy_d = 1'b1;
                    sar_d = CODE_ZERO;
                end
            end
            ST_OPEN: begin
                if (tick) begin
                    state_d = ST_GND;
                end
            end
            ST_GND: begin
                if (tick) begin
                    state_d = ST_TRIAL;
                    bit_d = MSB_IDX;
                    sar_d = CODE_MID;
                end
            end
            ST_TRIAL: begin
                if (tick) begin
                    state_d = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                if (tick) begin
                    // keep or drop the trial element
                    sar_d[bit_q] = comp_above_in;
                    if (bit_q == 4'h0) begin
                        state_d = ST_DONE;
                    end else begin
                        bit_d = bit_q - 4'h1;
                        sar_d[bit_q - 4'h1] = 1'b1; // next half step
                        state_d = ST_TRIAL;
                    end
                end
            end
            ST_DONE: begin
                result_d.code = sar_q;
                result_d.valid = 1'b1;
                busy_d = 1'b0;
                state_d = ST_ACQ;
            end
            default: begin
                state_d = ST_ACQ;
                busy_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_ACQ;
            strobe_q <= 1'b1;
            bit_q <= MSB_IDX;
            sar_q <= CODE_RESET;
            result_q <= '{code: CODE_RESET, valid: 1'b0};
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            strobe_q <= convert_strobe_in;
            bit_q <= bit_d;
            sar_q <= sar_d;
            result_q <= result_d;
            busy_q <= busy_d;
        end
    end

    // ****************************************
    // Array drive
    // ****************************************
    logic acquire;
    logic sample_open;

    // Switches open one state before the arrays leave the inputs
    // Arrays home again in the last state, so the code meets acquisition
    assign acquire = (state_q == ST_ACQ) || (state_q == ST_OPEN)
        || (state_q == ST_DONE);
    assign sample_open = (state_q != ST_ACQ) && (state_q != ST_DONE);

    // Identical switch drive keeps the arrays matched; the negative array
    // stays at ground through the trials, so the comparator sees the positive trial level
    array_switch_ctl u_pos (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .acquire_in(acquire),
        .sample_open_in(sample_open),
        .ref_mask_in(sar_q),
        .drive_out(pos_array_out)
    );

    array_switch_ctl u_neg (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .acquire_in(acquire),
        .sample_open_in(sample_open),
        .ref_mask_in(CODE_ZERO),
        .drive_out(neg_array_out)
    );

    assign positive_sample_switch_out = pos_array_out.sample_closed;
    assign negative_sample_switch_out = neg_array_out.sample_closed;
    assign powered_out = (state_q != ST_ACQ); // idle is powered down
    assign busy_out = busy_q;
    assign result_out = result_q;

    // ****************************************
    // Checks
    // ****************************************
    a_start_needs_rise: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_ACQ && !strobe_rise) |=> state_q == ST_ACQ)
        else $error("conversion began without a strobe rise");
    a_open_before_gnd: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        $rose(busy_q) |=> !positive_sample_switch_out
            && pos_array_out.to_input)
        else $error("arrays left inputs before switches opened");
    a_acq_plates_grounded: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_ACQ && $past(state_q) == ST_ACQ
            && $past(state_q, 2) == ST_ACQ)
        |-> positive_sample_switch_out && negative_sample_switch_out
            && pos_array_out.to_ref == CODE_ZERO)
        else $error("acquisition drive wrong");
    a_conv_length: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        $rose(busy_q) |-> ##[60:72] !busy_q)
        else $error("conversion length out of bounds");
    a_one_step_trial: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_TRIAL && $past(state_q) == ST_GND)
        |-> sar_q == CODE_MID)
        else $error("first trial is not midscale");
    a_keep_decision: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_DECIDE && tick)
        |=> sar_q[$past(bit_q)] == $past(comp_above_in))
        else $error("trial decision not kept");
    a_result_with_idle: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        result_q.valid |-> !busy_q && state_q == ST_ACQ)
        else $error("result without return to acquisition");
    a_full_scale: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (busy_q && comp_above_in) [*8] ##1 (busy_q && comp_above_in) [*8]
        ##0 (state_q == ST_DONE) |=> result_q.code[0])
        else $error("over-range lsb not set");
    a_zero_clamp: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (busy_q && !comp_above_in) [*8] ##1 (busy_q && !comp_above_in) [*8]
        ##0 (state_q == ST_DONE) |=> !result_q.code[0])
        else $error("under-range lsb not clear");

    // ****************************************
    // Step and output checks
    // ****************************************
    // Start only from a taken edge, straight into the open step
    a_rise_taken: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_ACQ && strobe_rise) |=> state_q == ST_OPEN && busy_q)
        else $error("strobe rise not taken");
    // Busy and the power state move together
    a_busy_with_power: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        busy_q == (state_q != ST_ACQ))
        else $error("busy and power state differ");
    a_neg_at_ground: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        neg_array_out.to_ref == CODE_ZERO)
        else $error("reference side array left ground");
    a_arrays_matched: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        positive_sample_switch_out == negative_sample_switch_out
            && pos_array_out.to_input == neg_array_out.to_input)
        else $error("arrays switched differently");
    a_open_in_trials: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_TRIAL || state_q == ST_DECIDE)
        |-> !positive_sample_switch_out && !pos_array_out.to_input)
        else $error("trial with switches closed or inputs tied");
    // Trial and decision steps wait for the conversion clock
    a_trial_waits_tick: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_TRIAL && !tick) |=> state_q == ST_TRIAL)
        else $error("trial left without a tick");
    a_decide_waits_tick: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_DECIDE && !tick) |=> state_q == ST_DECIDE)
        else $error("decision left without a tick");
    a_msb_first: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_TRIAL && $past(state_q) == ST_GND)
        |-> bit_q == MSB_IDX)
        else $error("first trial is not the msb");
    a_step_down: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_DECIDE && tick && bit_q != 4'h0)
        |=> bit_q == $past(bit_q) - 4'h1 && sar_q[bit_q])
        else $error("next trial is not the next lower bit");
    a_lsb_ends: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_DECIDE && tick && bit_q == 4'h0)
        |=> state_q == ST_DONE)
        else $error("trials did not end after the lsb");
    // Result must be this sample's register, no extra stage
    a_result_is_sample: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (state_q == ST_DONE)
        |=> result_q.valid && result_q.code == $past(sar_q))
        else $error("result is not this conversion");
    a_valid_one_cycle: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        result_q.valid |=> !result_q.valid)
        else $error("result valid longer than one cycle");
    a_code_holds: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        !result_q.valid |-> $stable(result_q.code))
        else $error("code changed without a result");

    c_conversion: cover property (@(posedge clk_in)
        disable iff (!nrst_in) result_q.valid);
    c_full_code: cover property (@(posedge clk_in)
        disable iff (!nrst_in) result_q.valid && result_q.code == CODE_FULL);
    c_zero_code: cover property (@(posedge clk_in)
        disable iff (!nrst_in) result_q.valid && result_q.code == CODE_ZERO);
    c_mid_code: cover property (@(posedge clk_in)
        disable iff (!nrst_in) result_q.valid && result_q.code == CODE_MID);
    c_refused_edge: cover property (@(posedge clk_in)
        disable iff (!nrst_in) state_q != ST_ACQ && strobe_rise);
endmodule

// ---- core/sar_seq_pkg.sv ----
// Purpose: Shared constants and types for the conversion sequencer
// Assumes: 25 MHz system clock
// Notes: Cycles per sample derive from the clock and rate named here
package sar_seq_pkg;

    localparam int unsigned CODE_W = 16;
    localparam int unsigned CLK_HZ = 25000000;
    // Sample rate ceiling, samples per second
    localparam int unsigned MAX_SPS = 250000;
    localparam int unsigned CYC_PER_SAMPLE = CLK_HZ / MAX_SPS;
    // Conversion clock: one enable per this many system cycles
    localparam int unsigned CONV_DIV = 2;
    // Settling of switch changes, in conversion-clock ticks
    localparam int unsigned SETTLE_TICKS = 1;
    localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_FULL = 16'hffff;
    localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_MID = 16'h8000;
    localparam logic [3:0] MSB_IDX = 4'hf;

    typedef enum logic [5:0] {
        ST_ACQ = 6'h01,
        ST_OPEN = 6'h02,
        ST_GND = 6'h04,
        ST_TRIAL = 6'h08,
        ST_DECIDE = 6'h10,
        ST_DONE = 6'h20
    } seq_state_t;

    // Drive bundle for one capacitor array
    typedef struct packed {
        logic sample_closed;
        logic to_input;
        logic [CODE_W-1:0] to_ref;
    } array_drive_t;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic valid;
    } result_t;

endpackage

// ---- dv/comparator_model.sv ----
// Purpose: Comparator and analog input seen through the trial arrays
// Assumes: Input level given in code steps, straight binary
// Notes: Output is meaningless while the arrays track the inputs
`timescale 1ns/10ps
module comparator_model
    import sar_seq_pkg::*;
(
    input wire logic clk_in,
    input wire array_drive_t pos_array_in,
    input wire array_drive_t neg_array_in,
    input wire logic signed [31:0] level_in,
    output logic comp_above_out
);
    // ****************************************
    // Decision
    // ****************************************
    logic junk_q = 1'b0;
    int trial;

    // Toggling junk so a result never leans on a stale decision
    always_ff @(posedge clk_in) begin
        junk_q <= ~junk_q;
    end

    // Residual at or above trial level keeps the element
    always_comb begin
        trial = int'(pos_array_in.to_ref) - int'(neg_array_in.to_ref);
        if (pos_array_in.to_input) begin
            comp_above_out = junk_q;
        end else begin
            comp_above_out = (level_in >= trial);
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Comparator model on the far side of the arrays
// Notes: Input levels in code steps; out-of-span values test clamps
`timescale 1ns/10ps
module tb_top
    import sar_seq_pkg::*;
;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic convert_strobe_in = 1'b1;
    logic comp_above;
    array_drive_t pos_a;
    array_drive_t neg_a;
    logic pos_sw;
    logic neg_sw;
    logic powered;
    logic busy;
    result_t result;
    int level = 0;
    int mismatches = 0;
    int n_compared = 0;

    always #20 clk_in = ~clk_in;

    sar_conversion_sequencer u_dut (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .convert_strobe_in(convert_strobe_in),
        .comp_above_in(comp_above),
        .pos_array_out(pos_a),
        .neg_array_out(neg_a),
        .positive_sample_switch_out(pos_sw),
        .negative_sample_switch_out(neg_sw),
        .powered_out(powered),
        .busy_out(busy),
        .result_out(result)
    );

    comparator_model u_comp (
        .clk_in(clk_in),
        .pos_array_in(pos_a),
        .neg_array_in(neg_a),
        .level_in(level),
        .comp_above_out(comp_above)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Toggle adds one refused strobe rise mid-conversion; hold leaves the strobe high
    task automatic convert(input int lvl, input logic [15:0] exp,
                           input bit toggle, input bit hold);
        int n;
        bit opened;
        bit first;
        logic [15:0] prev;
        n = 0;
        opened = 0;
        first = 1;
        prev = 16'h0000;
        @(posedge clk_in);
        convert_strobe_in <= 1'b1;
        level <= lvl;
        do begin
            @(posedge clk_in);
            #1;
            n++;
            if (n == 2) chk("busy_powered", 2'b11, {busy, powered});
            if (pos_a.to_input === 1'b0) chk("opened_first", 1, opened);
            if (first && pos_a.to_ref !== 16'h0000) begin
                chk("first_trial", 16'h8000, pos_a.to_ref);
                first = 0;
            end
            chk("one_step", 1, $countones(pos_a.to_ref & ~prev) <= 1);
            chk("neg_ground", 16'h0000, neg_a.to_ref);
            prev = pos_a.to_ref;
            if (pos_sw === 1'b0 && neg_sw === 1'b0) opened = 1;
            if (toggle && n == 3) convert_strobe_in <= 1'b0;
            if (toggle && n == 8) convert_strobe_in <= 1'b1;
            if (!hold && n == 12) convert_strobe_in <= 1'b0;
        end while (result.valid !== 1'b1 && n < 200);
        chk("code", exp, result.code);
        chk("busy_end", 0, busy);
        chk("powered_end", 0, powered);
        chk("closed", 2'b11, {pos_sw, neg_sw});
        chk("to_input", 1, pos_a.to_input & neg_a.to_input);
        chk("fits_rate", 1, n <= CYC_PER_SAMPLE);
    endtask

    // Strobe stays high with no new edge: nothing may start
    task automatic idle_check();
        repeat (80) begin
            @(posedge clk_in);
            #1;
            chk("idle_busy", 0, busy | result.valid);
        end
        @(posedge clk_in);
        convert_strobe_in <= 1'b0;
    endtask

    task automatic reset_mid();
        @(posedge clk_in);
        convert_strobe_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1;
        chk("reset_busy", 0, busy);
        chk("reset_closed", 2'b11, {pos_sw, neg_sw});
        idle_check();
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk("rst_sw", 2'b11, {pos_sw, neg_sw});
        chk("rst_in", 1, pos_a.to_input & neg_a.to_input);
        chk("rst_ref", 16'h0000, pos_a.to_ref);
        idle_check();
        convert(0, 16'h0000, 0, 0);
        convert(32768, 16'h8000, 1, 0);
        convert(65535, 16'hffff, 0, 0);
        convert(32767, 16'h7fff, 0, 0);
        convert(1, 16'h0001, 0, 0);
        convert(32769, 16'h8001, 0, 0);
        convert(200000, 16'hffff, 0, 0);
        convert(-300, 16'h0000, 0, 1);
        idle_check();
        reset_mid();
        convert(12345, 16'h3039, 0, 0);
        report_and_stop();
    end

    // Span covers roughly fifty times the expected run
    initial begin
        #2000000;
        mismatches++;
        report_and_stop();
    end
endmodule
